// *** dv/joy_link_properties.sv ***
// Concurrent checks on the link between the joystick device and its host.
`timescale 1ns/10ps
`default_nettype none
module joy_link_properties
	import joy_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	// Link signals, watched only.
	input  wire logic       ext_reset_low,
	input  wire logic       addr_sel,
	input  wire link_cmd_e  cmd,
	input  wire logic [6:0] dev_addr,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] rdata,
	input  wire logic       rvalid,
	input  wire logic       irq_oe,
	input  wire logic       motion_irq_low
);
	// ****************************************
	// Helper state
	// ****************************************
	logic [7:0] rd_addr_reg; // Offset of the last read taken.
	logic [7:0] low_cnt_reg; // Cycles the pin has been low, saturating.
	logic       fresh_reg;   // Pin reset seen and no write since.
	logic       x_seen_reg;  // X read since the last Y read.
	logic       func_reg;    // Tracked interrupt function bit.
	logic       hit;         // Request aimed at the strapped address.
	assign hit = (dev_addr == (addr_sel ? ADDR_ALT : ADDR_BASE));

	// History of the link; a pin or soft reset returns the mode to data-ready.
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_addr_reg <= 8'h00;
			low_cnt_reg <= 8'h00;
			fresh_reg   <= 1'b0;
			x_seen_reg  <= 1'b0;
			func_reg    <= 1'b0;
		end else begin
			if (cmd == CMD_READ)
				rd_addr_reg <= reg_addr;
			// Saturate so a long pulse never wraps back under the limit.
			if (ext_reset_low)
				low_cnt_reg <= 8'h00;
			else if (low_cnt_reg != 8'hff)
				low_cnt_reg <= low_cnt_reg + 8'h01;
			if (!ext_reset_low)
				fresh_reg <= 1'b1;
			else if (cmd == CMD_WRITE)
				fresh_reg <= 1'b0;
			if (cmd == CMD_READ && reg_addr == X_OFS)
				x_seen_reg <= 1'b1;
			else if (cmd == CMD_READ && reg_addr == Y_OFS)
				x_seen_reg <= 1'b0;
			if (!ext_reset_low)
				func_reg <= 1'b0;
			else if (cmd == CMD_WRITE && hit && reg_addr == CTRL_OFS)
				func_reg <= wdata[CTRL_SRST_BIT] ? 1'b0 : wdata[CTRL_FUNC_BIT];
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	a_addr_strap: assert property (cmd != CMD_NONE |-> hit)
		else $error("request sent to a foreign bus address");
	a_read_answer: assert property (cmd == CMD_READ && hit |=> rvalid)
		else $error("read not answered in the next cycle");
	a_rvalid_cause: assert property (rvalid |-> $past(cmd) == CMD_READ)
		else $error("read data valid without a read");
	a_pulse_length: assert property ($rose(ext_reset_low) |-> low_cnt_reg >= RST_PULSE_CYC)
		else $error("reset pin pulse too short");
	a_poll_defaults: assert property (rvalid && fresh_reg && rd_addr_reg == CTRL_OFS
		|-> (rdata & CTRL_DONE_MASK) == CTRL_RESET)
		else $error("control not at defaults after pin reset");
	a_scale_first: assert property (cmd == CMD_WRITE && fresh_reg
		|-> reg_addr == SCALE_OFS && wdata == SCALE_INIT)
		else $error("first write after reset is not the scaling value");
	a_pin_quiets: assert property (low_cnt_reg >= RST_PULSE_CYC + 2 |-> !irq_oe)
		else $error("interrupt held during pin reset");
	a_y_clears_irq: assert property (cmd == CMD_READ && hit && reg_addr == Y_OFS && !func_reg
		|-> ##[1:2] !irq_oe)
		else $error("Y read did not release the interrupt");
	a_x_before_y: assert property (cmd == CMD_READ && reg_addr == Y_OFS && irq_oe |-> x_seen_reg)
		else $error("sample consumed without reading X first");

	c_pin_reset: cover property ($rose(ext_reset_low));
	c_scale_write: cover property (cmd == CMD_WRITE && reg_addr == SCALE_OFS);
	c_irq_release: cover property ($rose(motion_irq_low));
endmodule
`default_nettype wire

// *** dv/joystick_position_readout_bench.sv ***
// Self-checking bench joining the joystick device and its host over the link.
`timescale 1ns/10ps
`default_nettype none
module joystick_position_readout_bench
	import joy_pkg::*;
;
	// ****************************************
	// Stimulus and monitor state
	// ****************************************
	logic       clk_sys_i;   // System clock.
	logic       reset_n_i;   // Power-on reset, active low.
	logic       clk_en_i;    // Clock enable for both ends.
	logic [7:0] sw_addr_i;   // Software port address.
	logic [7:0] sw_wdata_i;  // Software port write data.
	logic [7:0] sw_rdata_o;  // Software port read data.
	logic       sw_wr_i;     // Write strobe.
	logic       sw_rd_i;     // Read strobe.
	logic [7:0] knob_x_i;    // Knob X position.
	logic [7:0] knob_y_i;    // Knob Y position.
	logic [1:0] phase_o;     // Device cycle phase.
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0, low_len = 0, meas_len = 0, set_len = 0, set_t = 0, fall_t = 0;
	int x_t = 0, y_t = 0, wr_count = 0, lim_idx = 0, ctrl_idx = 0;
	logic [7:0] rd_addr_q, poll_val, first_wa, first_wd, x_val, y_val, ctrl_wd;
	logic [7:0] lim_val [4];
	bit         ctrl_seen = 0; // Final control write after the limits.

	joy_link_if link_bus ();
	joy_device i_joy_device (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
		.link(link_bus.dev), .knob_x_i(knob_x_i), .knob_y_i(knob_y_i), .phase_o(phase_o));
	joy_host i_joy_host (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
		.sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
		.sw_rdata_o(sw_rdata_o), .link(link_bus.host));
	joy_link_properties i_joy_link_properties (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
		.ext_reset_low(link_bus.ext_reset_low), .addr_sel(link_bus.addr_sel), .cmd(link_bus.cmd),
		.dev_addr(link_bus.dev_addr), .reg_addr(link_bus.reg_addr), .wdata(link_bus.wdata),
		.rdata(link_bus.rdata), .rvalid(link_bus.rvalid), .irq_oe(link_bus.irq_oe),
		.motion_irq_low(link_bus.motion_irq_low));

	// ****************************************
	// Link and phase monitor
	// ****************************************
	// Records what crossed the link; a pin reset restarts the measurement count.
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (phase_o == 2'b01)
			meas_len <= meas_len + 1;
		if (!link_bus.ext_reset_low) begin
			low_len <= low_len + 1;
			meas_len <= 0;
		end
		if (phase_o == 2'b11) begin
			set_len <= set_len + 1;
			set_t <= cyc;
		end
		if (!link_bus.motion_irq_low && fall_t == 0)
			fall_t <= cyc;
		if (link_bus.cmd == CMD_READ)
			rd_addr_q <= link_bus.reg_addr;
		if (link_bus.rvalid && rd_addr_q == CTRL_OFS && wr_count == 0)
			poll_val <= link_bus.rdata;
		if (link_bus.rvalid && rd_addr_q == X_OFS) begin
			x_val <= link_bus.rdata;
			x_t <= cyc;
		end
		if (link_bus.rvalid && rd_addr_q == Y_OFS) begin
			y_val <= link_bus.rdata;
			y_t <= cyc;
		end
		if (link_bus.cmd == CMD_WRITE) begin
			wr_count <= wr_count + 1;
			if (wr_count == 0) begin
				first_wa <= link_bus.reg_addr;
				first_wd <= link_bus.wdata;
			end
			if (link_bus.reg_addr inside {[XP_OFS:YN_OFS]}) begin
				lim_val[2'(link_bus.reg_addr - XP_OFS)] <= link_bus.wdata;
				lim_idx <= wr_count;
			end
			// An early control write during calibration is not the final one.
			if (link_bus.reg_addr == CTRL_OFS && lim_idx != 0) begin
				ctrl_wd <= link_bus.wdata;
				ctrl_idx <= wr_count;
				ctrl_seen <= 1'b1;
			end
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_range(input int got, input int lo, input int hi);
		samples_checked++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("mismatch at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		sw_addr_i <= a;
		sw_wdata_i <= d;
		sw_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		sw_wr_i <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe.
	task automatic sw_read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_i);
		sw_addr_i <= a;
		sw_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		sw_rd_i <= 1'b0;
		#1 d = sw_rdata_o;
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_reset_defaults();
		logic [7:0] d;
		check_byte({7'h00, link_bus.motion_irq_low}, 8'h01);
		sw_read(8'h04, d);
		check_byte(d, 8'h0a);
		sw_read(8'h01, d);
		check_byte(d, 8'h00);
		sw_read(8'h3f, d);
		check_byte(d, 8'h00);
		sw_write(8'h04, 8'h0c);
		sw_read(8'h04, d);
		check_byte(d, 8'h0c);
		// A write while the clock enable is low must leave the register untouched.
		clk_en_i <= 1'b0;
		sw_write(8'h04, 8'h55);
		clk_en_i <= 1'b1;
		sw_read(8'h04, d);
		check_byte(d, 8'h0c);
		check_byte({6'h00, phase_o}, 8'h01);
		$display("test_reset_defaults done");
	endtask

	// Full init: pin reset, poll, scaling, one-sample calibration, limits, control.
	task automatic test_init_sequence();
		logic [7:0] d;
		sw_write(8'h05, 8'h80);
		sw_write(8'h00, 8'h01);
		for (int i = 0; i < 100000 && !ctrl_seen; i++)
			@(posedge clk_sys_i);
		repeat (20) @(posedge clk_sys_i);
		check_byte({7'h00, ctrl_seen}, 8'h01);
		check_range(low_len, RST_PULSE_CYC, 1000);
		check_byte(poll_val & CTRL_DONE_MASK, CTRL_RESET);
		check_byte(first_wa, SCALE_OFS);
		check_byte(first_wd, SCALE_INIT);
		check_byte(x_val, 8'h03);
		check_byte(y_val, 8'hfd);
		check_range(y_t - x_t, 1, 1000);
		check_range(meas_len, 1, CONV_CYC);
		check_range(set_len, 1, 1);
		check_range(fall_t - set_t, 0, 2);
		// Threshold 12 around a zero of X = 3 and Y = -3.
		check_byte(lim_val[0], 8'h0f);
		check_byte(lim_val[1], 8'hf7);
		check_byte(lim_val[2], 8'h09);
		check_byte(lim_val[3], 8'hf1);
		check_byte(ctrl_wd, 8'h80);
		check_range(ctrl_idx - lim_idx, 1, 100);
		check_byte({6'h00, phase_o}, 8'h02);
		check_byte({7'h00, link_bus.motion_irq_low}, 8'h01);
		sw_read(8'h01, d);
		check_byte(d & 8'h01, 8'h01);
		sw_read(8'h02, d);
		check_byte(d, 8'h00);
		sw_read(8'h03, d);
		check_byte(d, 8'h00);
		$display("test_init_sequence done");
	endtask

	// ****************************************
	// Clock, watchdog and main sequence
	// ****************************************
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end

	// Init spans one 450 us measurement; the limit stays under 100000 cycles.
	initial begin
		#490000;
		bad_count++;
		$display("mismatch at %0t: run timed out", $time);
		summarize();
	end

	initial begin
		reset_n_i = 1'b0;
		clk_en_i = 1'b1;
		sw_addr_i = 8'h00;
		sw_wdata_i = 8'h00;
		sw_wr_i = 1'b0;
		sw_rd_i = 1'b0;
		knob_x_i = 8'h03;
		knob_y_i = 8'hfd;
		repeat (2) @(posedge clk_sys_i);
		reset_n_i <= 1'b1;
		test_reset_defaults();
		test_init_sequence();
		summarize();
	end
endmodule
`default_nettype wire

// *** src/joy_device.sv ***
// Joystick position readout device: registers, measurement cycle and interrupt pin.
//
// Contract
// - Power-on reset clears every internal register; code loads control F0h and limits 7Fh/80h instead.
// - Supply dip leaves registers undefined.
// - Host pulses reset low over 100ns.
// - Host polls control until F0h or F1h.
// - Host writes 16h to scaling first.
// - Host calibrates, sets limits, then control.
// - Host calibrates zero offsets itself.
// - Dead zone box from four limit registers.
// - Limit registers independently writable, signed.
// - Wake-up mode: low once outside box.
// - Data-ready mode: low per pair, Y read clears.
// - Signed 8-bit coordinates, same scale both axes.
// - Full +2.0mm displacement reads -128.
// - Any reset enters start-up, loads defaults.
// - Start-up does one measurement then waits.
// - Coordinates land within 450us conversion.
// - Interrupt updated after each measurement.
// - Wait length from mode bit and timebase.
// - Answers at address 40h or 41h.
`timescale 1ns/10ps
`default_nettype none
module joy_device
	import joy_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	input  wire logic        clk_en_i,
	// Link to the host.
	joy_link_if.dev          link,
	// Sensor side: signed knob position, positive to the left / upward.
	input  wire logic [7:0]  knob_x_i,
	input  wire logic [7:0]  knob_y_i,
	// Status.
	output logic [1:0]       phase_o
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {
		PH_STARTUP = 2'b00,
		PH_MEASURE = 2'b01,
		PH_SETIRQ  = 2'b11,
		PH_WAIT    = 2'b10
	} phase_e;

	typedef struct packed {
		logic [1:0]       rst_s;     // Reset pin synchroniser.
		logic [1:0]       asel_s;    // Address strap synchroniser.
		logic [CNT_W-1:0] low_cnt;   // Reset pin low duration.
		phase_e           phase;     // Measurement cycle phase.
		logic [CNT_W-1:0] cnt;       // Conversion / wait counter.
		logic [7:0]       ctrl;      // Control register.
		logic [7:0]       xr;        // X result.
		logic [7:0]       yr;        // Y result.
		logic [3:0][7:0]  lim;       // Dead zone limits: +X, -X, +Y, -Y.
		logic [7:0]       scale;     // Scaling register.
		logic             irq;       // Interrupt asserted.
		logic [7:0]       rdata;     // Read data.
		logic             rvalid;    // Read valid.
	} dev_s;

	dev_s st_reg;  // Registered state.
	dev_s st_next; // Next state.

	logic hit;      // Command addressed to this device.
	logic outside;  // Sample outside dead zone.
	logic [CNT_W-1:0] wait_len; // Current wait length.

	// ****************************************
	// Next-state logic
	// ****************************************
	// Fills the next copy of the whole state every cycle.
	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		st_next.rst_s = {st_reg.rst_s[0], link.ext_reset_low};
		st_next.asel_s = {st_reg.asel_s[0], link.addr_sel};
		hit = (link.dev_addr == (st_reg.asel_s[1] ? ADDR_ALT : ADDR_BASE));
		outside = ($signed(st_reg.xr) > $signed(st_reg.lim[0])) || ($signed(st_reg.xr) < $signed(st_reg.lim[1]))
			|| ($signed(st_reg.yr) > $signed(st_reg.lim[2])) || ($signed(st_reg.yr) < $signed(st_reg.lim[3]));
		wait_len = CNT_W'(WAIT_BASE_CYC) * CNT_W'({st_reg.ctrl[CTRL_TB_HI:CTRL_TB_LO], 1'b1})
			* (st_reg.ctrl[CTRL_LP_BIT] ? CNT_W'(1) : CNT_W'(4));
		// Pin low time counts only while the synchronised level is low.
		if (!st_reg.rst_s[1]) begin
			st_next.low_cnt = (st_reg.low_cnt == '1) ? st_reg.low_cnt : st_reg.low_cnt + 1'b1;
		end else begin
			st_next.low_cnt = '0;
		end
		// Register accesses; data-ready clear happens on the Y read.
		if (link.cmd == CMD_READ && hit) begin
			st_next.rvalid = 1'b1;
			case (link.reg_addr)
				CTRL_OFS:  st_next.rdata = st_reg.ctrl;
				X_OFS:     st_next.rdata = st_reg.xr;
				Y_OFS:     st_next.rdata = st_reg.yr;
				XP_OFS:    st_next.rdata = st_reg.lim[0];
				XN_OFS:    st_next.rdata = st_reg.lim[1];
				YP_OFS:    st_next.rdata = st_reg.lim[2];
				YN_OFS:    st_next.rdata = st_reg.lim[3];
				SCALE_OFS: st_next.rdata = st_reg.scale;
				default:   st_next.rdata = 8'h00;
			endcase
			if (link.reg_addr == Y_OFS && !st_reg.ctrl[CTRL_FUNC_BIT]) begin
				st_next.irq = 1'b0;
			end
			// Reading Y consumes the ready flag as well.
			if (link.reg_addr == Y_OFS) begin
				st_next.ctrl[CTRL_DONE_BIT] = 1'b0;
			end
		end else if (link.cmd == CMD_WRITE && hit) begin
			case (link.reg_addr)
				CTRL_OFS:  st_next.ctrl[7:1] = link.wdata[7:1];
				XP_OFS:    st_next.lim[0] = link.wdata;
				XN_OFS:    st_next.lim[1] = link.wdata;
				YP_OFS:    st_next.lim[2] = link.wdata;
				YN_OFS:    st_next.lim[3] = link.wdata;
				SCALE_OFS: st_next.scale = link.wdata;
				default:   st_next.scale = st_reg.scale;
			endcase
		end
		// Measurement cycle.
		case (st_reg.phase)
			PH_STARTUP: begin
				st_next.phase = PH_MEASURE;
				st_next.cnt = '0;
			end
			PH_MEASURE: begin
				if (st_reg.cnt >= CNT_W'(CONV_CYC - 1)) begin
					st_next.xr = knob_x_i;
					st_next.yr = knob_y_i;
					st_next.ctrl[CTRL_DONE_BIT] = 1'b1;
					st_next.phase = PH_SETIRQ;
				end else begin
					st_next.cnt = st_reg.cnt + 1'b1;
				end
			end
			PH_SETIRQ: begin
				// pin by mode; set beats clear
				if (st_reg.ctrl[CTRL_FUNC_BIT]) begin
					st_next.irq = outside;
				end else begin
					st_next.irq = 1'b1;
				end
				st_next.phase = PH_WAIT;
				st_next.cnt = '0;
			end
			PH_WAIT: begin
				if (st_reg.cnt >= wait_len - 1'b1) begin
					st_next.phase = PH_MEASURE;
					st_next.cnt = '0;
				end else begin
					st_next.cnt = st_reg.cnt + 1'b1;
				end
			end
			default: st_next.phase = PH_STARTUP;
		endcase
		// soft or pin reset reloads defaults
		if (st_reg.ctrl[CTRL_SRST_BIT] || st_reg.low_cnt >= CNT_W'(RST_PULSE_CYC - 1)) begin
			st_next.phase = PH_STARTUP;
			st_next.ctrl = CTRL_RESET;
			st_next.irq = 1'b0;
			st_next.xr = 8'h00;
			st_next.yr = 8'h00;
			st_next.scale = SCALE_RESET;
			st_next.lim[0] = LIMIT_POS_RST;
			st_next.lim[1] = LIMIT_NEG_RST;
			st_next.lim[2] = LIMIT_POS_RST;
			st_next.lim[3] = LIMIT_NEG_RST;
			st_next.cnt = '0;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	// The asynchronous reset stands in for the power-on reset cell.
	// no re-arm: reset_n_i loads the reset image here; soft and pin reset act through st_next
	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_reg <= '{rst_s: 2'b11, asel_s: 2'b00, low_cnt: '0, phase: PH_STARTUP, cnt: '0,
				ctrl: CTRL_RESET, xr: 8'h00, yr: 8'h00,
				lim: {LIMIT_NEG_RST, LIMIT_POS_RST, LIMIT_NEG_RST, LIMIT_POS_RST},
				scale: SCALE_RESET, irq: 1'b0, rdata: 8'h00, rvalid: 1'b0};
		end else if (clk_en_i) begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from flip-flops; the enable bit does not gate the interrupt.
	assign link.rdata  = st_reg.rdata;
	assign link.rvalid = st_reg.rvalid;
	assign link.irq_oe = st_reg.irq;
	assign phase_o     = st_reg.phase;

endmodule
`default_nettype wire

// *** src/joy_host.sv ***
// Host controller: reset, init sequence, limit programming and sample reads.
`timescale 1ns/10ps
`default_nettype none
module joy_host
	import joy_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic        clk_sys_i,
	input  wire logic        reset_n_i,
	input  wire logic        clk_en_i,
	// Software command port.
	input  wire logic [7:0]  sw_addr_i,
	input  wire logic [7:0]  sw_wdata_i,
	input  wire logic        sw_wr_i,
	input  wire logic        sw_rd_i,
	output logic [7:0]       sw_rdata_o,
	// Link to the device.
	joy_link_if.host         link
);

	// ****************************************
	// Own registers
	// ****************************************
	localparam logic [7:0] H_CMD    = 8'h00; // Write 1: start init.
	localparam logic [7:0] H_STATUS = 8'h01; // [0] ready, [1] new sample.
	localparam logic [7:0] H_X      = 8'h02; // Last X, offset applied.
	localparam logic [7:0] H_Y      = 8'h03; // Last Y, offset applied.
	localparam logic [7:0] H_THR    = 8'h04; // Dead zone half width.
	localparam logic [7:0] H_CTRL   = 8'h05; // Control value to program.

	typedef enum logic [3:0] {
		H_IDLE  = 4'h0, H_RST   = 4'h1, H_POLL  = 4'h3, H_PWAIT = 4'h2,
		H_SCAL  = 4'h6, H_CAL   = 4'h7, H_LIM   = 4'h5, H_CFG   = 4'h4,
		H_RUN   = 4'hc, H_RDX   = 4'hd, H_RDY   = 4'hf
	} hstate_e;

	typedef struct packed {
		hstate_e          st;
		logic [CNT_W-1:0] cnt;
		logic [1:0]       irq_s;   // Interrupt pin synchroniser.
		link_cmd_e        cmd;
		logic [7:0]       raddr;
		logic [7:0]       wdata;
		logic             rst_low;
		logic [7:0]       thr, cfg, xo, yo, xs, ys;
		logic             ready, fresh;
		logic [7:0]       srd;
	} host_s;

	host_s h_reg;
	host_s h_next;
	logic  irq_on;

	// Sequencer plus software port.
	always_comb begin
		h_next = h_reg;
		h_next.cmd = CMD_NONE;
		h_next.irq_s = {h_reg.irq_s[0], ~link.motion_irq_low};
		irq_on = h_reg.irq_s[1];
		h_next.srd = 8'h00;
		if (sw_rd_i) begin
			case (sw_addr_i)
				H_STATUS: h_next.srd = {6'h00, h_reg.fresh, h_reg.ready};
				H_X:      h_next.srd = h_reg.xs;
				H_Y:      h_next.srd = h_reg.ys;
				H_THR:    h_next.srd = h_reg.thr;
				H_CTRL:   h_next.srd = h_reg.cfg;
				default:  h_next.srd = 8'h00;
			endcase
			if (sw_addr_i == H_Y) h_next.fresh = 1'b0;
		end
		if (sw_wr_i) begin
			if (sw_addr_i == H_THR) h_next.thr = sw_wdata_i;
			if (sw_addr_i == H_CTRL) h_next.cfg = sw_wdata_i;
		end
		case (h_reg.st)
			H_IDLE: if (sw_wr_i && sw_addr_i == H_CMD && sw_wdata_i[0]) begin
				h_next.st = H_RST; h_next.rst_low = 1'b1; h_next.cnt = '0; h_next.ready = 1'b0;
			end
			H_RST: if (h_reg.cnt >= CNT_W'(RST_PULSE_CYC + 4)) begin
				h_next.rst_low = 1'b0; h_next.st = H_POLL;
			end else h_next.cnt = h_reg.cnt + 1'b1;
			H_POLL: begin
				h_next.cmd = CMD_READ; h_next.raddr = CTRL_OFS; h_next.st = H_PWAIT;
			end
			H_PWAIT: if (link.rvalid) begin
				if ((link.rdata & CTRL_DONE_MASK) == CTRL_RESET) begin
					h_next.cmd = CMD_WRITE; h_next.raddr = SCALE_OFS; h_next.wdata = SCALE_INIT;
					h_next.st = H_SCAL;
				end else h_next.st = H_POLL;
			end
			H_SCAL: if (irq_on) begin
				// zero offset from one sample
				// Results read 00 until the first measurement ends, so wait for the data-ready pin.
				h_next.cmd = CMD_READ; h_next.raddr = X_OFS; h_next.st = H_CAL; h_next.cnt = '0;
			end
			H_CAL: if (link.rvalid) begin
				if (h_reg.cnt == '0) begin
					h_next.xo = 8'(-link.rdata); h_next.cmd = CMD_READ; h_next.raddr = Y_OFS;
					h_next.cnt = CNT_W'(1);
				end else begin
					h_next.yo = 8'(-link.rdata); h_next.st = H_LIM; h_next.cnt = '0;
				end
			end
			H_LIM: begin
				h_next.cmd = CMD_WRITE;
				h_next.raddr = XP_OFS + h_reg.cnt[7:0];
				case (h_reg.cnt[1:0])
					2'h0: h_next.wdata = h_reg.thr - h_reg.xo;
					2'h1: h_next.wdata = 8'(-h_reg.thr) - h_reg.xo;
					2'h2: h_next.wdata = h_reg.thr - h_reg.yo;
					default: h_next.wdata = 8'(-h_reg.thr) - h_reg.yo;
				endcase
				h_next.cnt = h_reg.cnt + 1'b1;
				if (h_reg.cnt[1:0] == 2'h3) h_next.st = H_CFG;
			end
			H_CFG: begin
				h_next.cmd = CMD_WRITE; h_next.raddr = CTRL_OFS; h_next.wdata = h_reg.cfg;
				h_next.st = H_RUN; h_next.ready = 1'b1;
			end
			H_RUN: if (h_reg.cnt != '0) begin
				// The synchronised pin lags the Y read; let it settle so a pair is not read twice.
				h_next.cnt = h_reg.cnt - 1'b1;
			end else if (irq_on) begin
				h_next.cmd = CMD_READ; h_next.raddr = X_OFS; h_next.st = H_RDX;
			end
			H_RDX: if (link.rvalid) begin
				h_next.xs = link.rdata + h_reg.xo; h_next.cmd = CMD_READ; h_next.raddr = Y_OFS;
				h_next.st = H_RDY;
			end
			H_RDY: if (link.rvalid) begin
				h_next.ys = link.rdata + h_reg.yo; h_next.fresh = 1'b1; h_next.st = H_RUN;
				h_next.cnt = CNT_W'(2);
			end
			default: h_next.st = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			h_reg <= '{st: H_IDLE, cnt: '0, irq_s: 2'b00, cmd: CMD_NONE, raddr: 8'h00, wdata: 8'h00,
				rst_low: 1'b0, thr: 8'h0a, cfg: 8'h00, xo: 8'h00, yo: 8'h00, xs: 8'h00, ys: 8'h00,
				ready: 1'b0, fresh: 1'b0, srd: 8'h00};
		end else if (clk_en_i) begin
			h_reg <= h_next;
		end
	end

	assign link.ext_reset_low = ~h_reg.rst_low;
	assign link.addr_sel      = 1'b0;
	assign link.dev_addr      = ADDR_BASE;
	assign link.cmd           = h_reg.cmd;
	assign link.reg_addr      = h_reg.raddr;
	assign link.wdata         = h_reg.wdata;
	assign sw_rdata_o         = h_reg.srd;

endmodule
`default_nettype wire

// *** src/joy_link_if.sv ***
// Link between the joystick device and its host controller.
`timescale 1ns/10ps
`default_nettype none
interface joy_link_if;
	import joy_pkg::*;
	logic       ext_reset_low;   // Reset pin, active low, host driven.
	logic       addr_sel;        // Address select strap.
	link_cmd_e  cmd;             // One-cycle command.
	logic [6:0] dev_addr;        // Target bus address.
	logic [7:0] reg_addr;        // Register offset.
	logic [7:0] wdata;           // Write data.
	logic [7:0] rdata;           // Read data, cycle after read.
	logic       rvalid;          // Read data valid.
	logic       irq_oe;          // Device pulls interrupt low.
	logic       motion_irq_low;  // Resolved open-drain line.
	assign motion_irq_low = ~irq_oe;
	modport dev  (input ext_reset_low, addr_sel, cmd, dev_addr, reg_addr, wdata,
	              output rdata, rvalid, irq_oe);
	modport host (output ext_reset_low, addr_sel, cmd, dev_addr, reg_addr, wdata,
	              input rdata, rvalid, motion_irq_low);
endinterface
`default_nettype wire

// *** src/joy_pkg.sv ***
// Shared constants and types for the joystick position readout device and its host controller.
package joy_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] CTRL_OFS    = 8'h0f; // Control and status.
	localparam logic [7:0] X_OFS       = 8'h10; // X coordinate.
	localparam logic [7:0] Y_OFS       = 8'h11; // Y coordinate, read clears interrupt in data-ready mode.
	localparam logic [7:0] XP_OFS      = 8'h12; // Positive X limit.
	localparam logic [7:0] XN_OFS      = 8'h13; // Negative X limit.
	localparam logic [7:0] YP_OFS      = 8'h14; // Positive Y limit.
	localparam logic [7:0] YN_OFS      = 8'h15; // Negative Y limit.
	localparam logic [7:0] SCALE_OFS   = 8'h2d; // Travel scaling.

	// ****************************************
	// Control fields and values
	// ****************************************
	localparam int         CTRL_LP_BIT    = 7;     // Idle / low-power mode.
	localparam int         CTRL_TB_HI     = 6;     // Timebase field top bit.
	localparam int         CTRL_TB_LO     = 4;     // Timebase field low bit.
	localparam int         CTRL_IRQEN_BIT = 3;     // Interrupt output enable.
	localparam int         CTRL_FUNC_BIT  = 2;     // 1 wake-up, 0 data-ready.
	localparam int         CTRL_SRST_BIT  = 1;     // Soft reset request.
	localparam int         CTRL_DONE_BIT  = 0;     // Sample ready status.
	localparam logic [7:0] CTRL_RESET     = 8'hf0; // Value after reset.
	localparam logic [7:0] CTRL_DONE_MASK = 8'hfe; // Mask for completion poll.
	localparam logic [7:0] SCALE_INIT     = 8'h16; // Scaling written by host.
	localparam logic [7:0] SCALE_RESET    = 8'h00; // Scaling after reset.
	localparam logic [7:0] LIMIT_POS_RST  = 8'h7f; // Positive limit reset.
	localparam logic [7:0] LIMIT_NEG_RST  = 8'h80; // Negative limit reset.
	localparam logic [6:0] ADDR_BASE      = 7'h40; // Bus address, select pin low.
	localparam logic [6:0] ADDR_ALT       = 7'h41; // Bus address, select pin high.

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ       = 200;  // System clock rate.
	localparam int RST_PULSE_NS  = 100; // Least reset pulse length.
	localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000 + 1;
	localparam int CONV_US       = 450; // Longest conversion time.
	localparam int CONV_CYC      = CONV_US * CLK_MHZ; // Exact product, no rounding.
	localparam int WAIT_BASE_CYC = 4000; // Wait unit, times twice the timebase field plus one.
	localparam int CNT_W         = 24;   // Counter width.

	// ****************************************
	// Link command codes
	// ****************************************
	typedef enum logic [1:0] {
		CMD_NONE  = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_READ  = 2'h2
	} link_cmd_e;

endpackage
